// ---- adc_seq_pkg.sv ----
package adc_seq_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS   = 8'h30;
   localparam logic [7:0] OPTION_OFS = 8'h34;
   localparam logic [7:0] STATUS_OFS = 8'h38;
   localparam logic [7:0] RESULT_OFS = 8'h40;

   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int CTRL_DONE_POS  = 7;
   localparam int CTRL_EIGHT_POS = 6;
   localparam int CTRL_CONT_POS  = 5;
   localparam int CTRL_GROUP_POS = 4;
   localparam logic [7:0] CTRL_RST = 8'h00;

   // ---------------------------------------------------------------
   // option register fields
   // ---------------------------------------------------------------
   localparam int OPT_POWER_POS = 0;
   localparam int OPT_RC_POS    = 1;
   localparam int OPT_DLY_POS   = 2;
   localparam logic [2:0] OPT_RST = 3'h0;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ         = 100;
   localparam int RC_KHZ          = 1500;
   localparam int RC_DIV          = (CLK_MHZ * 1000) / RC_KHZ;
   localparam int CONV_TICKS      = 36;
   localparam int POWER_SETTLE_US = 100;
   localparam int RC_SETTLE_MS    = 10;
   localparam int RESULT_W        = 10;

   typedef struct packed {
      logic [3:0] channel;
      logic       start;
      logic       abort;
   } conv_req_t;

   typedef struct packed {
      logic                done;
      logic [RESULT_W-1:0] value;
   } conv_rsp_t;

endpackage : adc_seq_pkg

// ---- sar_engine.sv ----
`timescale 1ns/1ps
module sar_engine
   import adc_seq_pkg::*;
#(
   parameter int TICKS = CONV_TICKS
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic                tick_en,
   input  wire logic                hold,
   input  wire conv_req_t           req,
   input  wire logic                cmp_in,
   output logic [3:0]               mux_sel,
   output logic                     sample,
   output conv_rsp_t                rsp
);

   typedef struct packed {
      logic                busy;
      logic [5:0]          cnt;
      logic [3:0]          ch;
      logic [RESULT_W-1:0] sar;
      logic [3:0]          bitn;
      logic                smp;
      conv_rsp_t           rsp;
   } eng_t;

   eng_t q, d;

   always_comb begin
      d = q;
      d.rsp.done = 1'b0;
      d.smp      = 1'b0;
      if (req.abort) begin
         d.busy = 1'b0;
      end else if (req.start) begin
         d.busy = 1'b1;
         d.ch   = req.channel;
         d.cnt  = '0;
         d.sar  = '0;
         d.bitn = 4'(RESULT_W - 1);
         d.smp  = 1'b1;
      end else if (q.busy && hold) begin
         d.cnt = '0;
         d.sar = '0;
         d.bitn = 4'(RESULT_W - 1);
      end else if (q.busy && tick_en) begin
         d.cnt = q.cnt + 6'd1;
         if (q.cnt == 6'd0) begin
            d.smp = 1'b1;
         end
         if (q.cnt >= 6'd2 && q.cnt < 6'(2 + RESULT_W)) begin
            d.sar[q.bitn] = cmp_in;
            d.bitn        = q.bitn - 4'd1;
         end
         if (q.cnt == 6'(TICKS - 1)) begin
            d.busy       = 1'b0;
            d.rsp.done   = 1'b1;
            d.rsp.value  = q.sar;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign mux_sel = q.ch;
   assign sample  = q.smp;
   assign rsp     = q.rsp;

endmodule : sar_engine

// ---- adc_sequence_control.sv ----
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module adc_sequence_control
   import adc_seq_pkg::*;
#(
   parameter int RC_DIVIDE = RC_DIV,
   parameter int TICKS     = CONV_TICKS
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        stop_mode,
   input  wire logic        wait_mode,
   input  wire logic        cmp_in,
   output logic [3:0]       mux_sel,
   output logic             sample,
   output logic             converter_power,
   output logic             rc_osc_enable
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic                awok;
      logic [7:0]          awa;
      logic                wok;
      logic [31:0]         wd;
      logic [3:0]          ws;
      logic                bv;
      logic                rv;
      logic [31:0]         rd;
      logic [1:0]          rr;
      logic [1:0]          br;
      logic [7:0]          ctrl;
      logic [2:0]          opt;
      logic                run;
      logic                eng_busy;
      logic [2:0]          idx;
      logic                kick;
      logic [7:0]          div;
      logic                tick;
      logic                held;
      logic [3:0]          mux;
      logic                smp;
      logic                pwr;
      logic                rcen;
   } st_t;

   st_t q, d;

   logic [RESULT_W-1:0] slot_q [8];
   logic [RESULT_W-1:0] slot_d [8];

   conv_req_t req;
   conv_rsp_t rsp;
   logic [3:0] eng_mux;
   logic       eng_smp;
   logic       suspend;

   assign suspend = stop_mode | wait_mode;

   sar_engine #(
      .TICKS   (TICKS)
   ) u_engine (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick_en (q.tick),
      .hold    (suspend),
      .req     (req),
      .cmp_in  (cmp_in),
      .mux_sel (eng_mux),
      .sample  (eng_smp),
      .rsp     (rsp)
   );

   // ---------------------------------------------------------------
   // sequence helpers
   // ---------------------------------------------------------------
   function automatic logic [3:0] chan_of(input logic [7:0] c, input logic [2:0] i);
      logic [3:0] ch;
      ch = c[3:0];
      if (c[CTRL_GROUP_POS]) begin
         if (c[CTRL_EIGHT_POS]) begin
            ch = {c[3], i};
         end else begin
            ch = {c[3:2], i[1:0]};
         end
      end
      return ch;
   endfunction : chan_of

   function automatic logic [2:0] slot_of(input logic [7:0] c, input logic [2:0] i);
      logic [2:0] s;
      s = c[CTRL_EIGHT_POS] ? i : {1'b1, i[1:0]};
      return s;
   endfunction : slot_of

   function automatic logic [2:0] last_of(input logic [7:0] c);
      logic [2:0] l;
      l = c[CTRL_EIGHT_POS] ? 3'd7 : 3'd3;
      return l;
   endfunction : last_of

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   logic [7:0]  rsel;
   logic        ctrl_wr;
   logic        opt_wr;
   logic        ok_w;

   always_comb begin
      d       = q;
      slot_d  = slot_q;
      req     = '0;
      rsel    = '0;
      ctrl_wr = 1'b0;
      opt_wr  = 1'b0;
      ok_w    = 1'b0;

      // bus write channel
      if (s_axi_awvalid && !q.awok && !q.bv) begin
         d.awok = 1'b1;
         d.awa  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.wok && !q.bv) begin
         d.wok = 1'b1;
         d.wd  = s_axi_wdata;
         d.ws  = s_axi_wstrb;
      end
      if (q.awok && q.wok && !q.bv) begin
         d.awok = 1'b0;
         d.wok  = 1'b0;
         d.bv   = 1'b1;
         ok_w   = (q.awa == CTRL_OFS) || (q.awa == OPTION_OFS);
         d.br   = ok_w ? 2'b00 : 2'b10;
         ctrl_wr = (q.awa == CTRL_OFS) && q.ws[0];
         opt_wr  = (q.awa == OPTION_OFS) && q.ws[0];
      end
      if (q.bv && s_axi_bready) begin
         d.bv = 1'b0;
      end

      // bus read channel
      if (s_axi_arvalid && !q.rv) begin
         d.rv = 1'b1;
         d.rr = 2'b00;
         d.rd = '0;
         rsel = s_axi_araddr;
         if (rsel == CTRL_OFS) begin
            d.rd[7:0] = q.ctrl;
         end else if (rsel == OPTION_OFS) begin
            d.rd[2:0] = q.opt;
         end else if (rsel == STATUS_OFS) begin
            d.rd[3:0] = {q.run, q.idx};
         end else if (rsel >= RESULT_OFS && rsel < 8'(RESULT_OFS + 8'd32)
                      && rsel[1:0] == 2'b00) begin
            d.rd[15:6] = slot_q[rsel[4:2]];
         end else begin
            d.rr = 2'b10;
         end
      end
      if (q.rv && s_axi_rready) begin
         d.rv = 1'b0;
      end

      // conversion clock divider
      d.tick = 1'b0;
      if (q.opt[OPT_RC_POS]) begin
         if (q.div == 8'(RC_DIVIDE - 1)) begin
            d.div  = '0;
            d.tick = 1'b1;
         end else begin
            d.div = q.div + 8'd1;
         end
      end else begin
         d.div  = '0;
         d.tick = 1'b1;
      end

      // option register
      if (opt_wr) begin
         d.opt = q.wd[2:0];
      end
      d.pwr  = q.opt[OPT_POWER_POS];
      d.rcen = q.opt[OPT_RC_POS] & ~stop_mode;

      // sequencer
      d.kick = 1'b0;
      d.held = suspend;
      if (ctrl_wr) begin
         d.ctrl = {1'b0, q.wd[6:0]};
         d.idx  = '0;
         d.run  = 1'b1;
         d.eng_busy = 1'b0;
         d.kick = 1'b1;
         req.abort = 1'b1;
      end else if (!q.opt[OPT_POWER_POS]) begin
         d.run = 1'b0;
         d.eng_busy = 1'b0;
         req.abort = q.run;
      end else if (!suspend && (q.kick || (q.held && q.eng_busy))) begin
         req.start   = 1'b1;
         req.channel = chan_of(q.ctrl, q.idx);
         d.eng_busy  = 1'b1;
      end else if (rsp.done && q.run) begin
         slot_d[slot_of(q.ctrl, q.idx)] = rsp.value;
         d.eng_busy = 1'b0;
         if (q.idx == last_of(q.ctrl)) begin
            d.ctrl[CTRL_DONE_POS] = 1'b1;
            d.idx = '0;
            if (q.ctrl[CTRL_CONT_POS]) begin
               d.kick = 1'b1;
            end else begin
               d.run = 1'b0;
            end
         end else begin
            d.idx  = q.idx + 3'd1;
            d.kick = 1'b1;
         end
      end else if (suspend) begin
         d.kick = q.kick;
      end
      if (!q.run) begin
         d.kick = d.kick & ctrl_wr;
      end

      d.mux = eng_mux;
      d.smp = eng_smp;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         for (int i = 0; i < 8; i++) begin
            slot_q[i] <= '0;
         end
      end else begin
         q      <= d;
         slot_q <= slot_d;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready   = q.awok;
   assign s_axi_wready    = q.wok;
   assign s_axi_bvalid    = q.bv;
   assign s_axi_bresp     = q.br;
   assign s_axi_arready   = q.rv;
   assign s_axi_rvalid    = q.rv;
   assign s_axi_rdata     = q.rd;
   assign s_axi_rresp     = q.rr;
   assign mux_sel         = q.mux;
   assign sample          = q.smp;
   assign converter_power = q.pwr;
   assign rc_osc_enable   = q.rcen;

endmodule : adc_sequence_control

// ---- adc_seq_monitor.sv ----
`timescale 1ns/1ps
module adc_seq_monitor
   import adc_seq_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        stop_mode,
   input wire logic        wait_mode,
   input wire logic [3:0]  mux_sel,
   input wire logic        sample,
   input wire logic        converter_power,
   input wire logic        rc_osc_enable
);
   // ---
   // checks
   // ---
   logic opt_wr_q;
   logic pwr_q;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         opt_wr_q <= 1'b0;
         pwr_q    <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) opt_wr_q <= (s_axi_awaddr == OPTION_OFS);
         if (s_axi_wvalid && s_axi_wready) pwr_q <= s_axi_wdata[OPT_POWER_POS];
      end
   end
   AST_PWR: assert property ($rose(s_axi_bvalid) && opt_wr_q
      |-> ##[0:2] converter_power == pwr_q) else $error("power bit not applied");
   AST_RC_STOP: assert property (stop_mode |=> !rc_osc_enable)
      else $error("rc clock on in stop");
   AST_UNPWR: assert property (!converter_power [*3] |-> !sample)
      else $error("sample while unpowered");
   AST_SUSP: assert property ((stop_mode || wait_mode) [*3]
      |-> !sample && $stable(mux_sel)) else $error("activity while suspended");
   AST_BHOLD: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not retired");
   AST_RHOLD: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid) else $error("read data not retired");
   AST_RDERR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr < CTRL_OFS
      |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000) else $error("bad unmapped read");
   AST_AWPULSE: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready not a pulse");
endmodule : adc_seq_monitor

bind adc_sequence_control adc_seq_monitor u_adc_seq_monitor (.*);

// ---- analog_source_model.sv ----
`timescale 1ns/1ps
module analog_source_model (
   input  wire logic       aclk,
   input  wire logic [3:0] mux_sel,
   input  wire logic       sample,
   input  wire logic       converter_power,
   input  wire logic       flip,
   output logic            cmp_in
);
   // ---
   // pin model: odd channels sit high while flip is low, even channels while flip is set
   // ---
   logic [3:0] chan_q[$];
   int         n_samp = 0;
   logic       wobble = 1'b0;
   logic       samp_q = 1'b0;
   always @(posedge aclk) begin
      wobble <= ~wobble;
      samp_q <= sample;
      if (sample) n_samp <= n_samp + 1;
      if (samp_q && (chan_q.size() == 0 || chan_q[$] !== mux_sel)) chan_q.push_back(mux_sel);
   end
   // unpowered comparator answers nothing stable
   assign cmp_in = converter_power ? (mux_sel[0] ^ flip) : wobble;
endmodule : analog_source_model

// ---- adc_sequence_control_tb_top.sv ----
`timescale 1ns/1ps
module adc_sequence_control_tb_top;
   import adc_seq_pkg::*;
   // ---
   // bench
   // ---
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, stop_mode, wait_mode, cmp_in, sample, converter_power;
   logic        rc_osc_enable, flip;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb, mux_sel;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic [31:0] exp_s [8];
   bit          known [8];
   logic [3:0]  exp_q[$];
   int          err_total = 0;
   int          num_checks = 0;
   int          cyc = 0;
   adc_sequence_control #(.RC_DIVIDE(4), .TICKS(16)) u_adc_sequence_control (.*);
   analog_source_model u_analog_source_model (.*);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk("bresp", 32'h0, 32'(s_axi_bresp));
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd
   task automatic run(input logic [7:0] c, input logic [1:0] lp);
      int i;
      int n;
      logic [3:0] ch;
      u_analog_source_model.chan_q.delete();
      exp_q.delete();
      flip <= 1'($urandom());
      wr(CTRL_OFS, {24'h0, c});
      rd(CTRL_OFS);
      chk("done clear", 32'h0, 32'(rv[CTRL_DONE_POS]));
      repeat (20) @(posedge aclk);
      {stop_mode, wait_mode} <= lp;
      repeat (40) @(posedge aclk);
      {stop_mode, wait_mode} <= 2'b00;
      n = 0;
      do begin
         rd(CTRL_OFS);
         n++;
      end while (!rv[CTRL_DONE_POS] && n < 400);
      chk("done", 32'h1, 32'(rv[CTRL_DONE_POS]));
      if (c[CTRL_CONT_POS]) begin
         flip <= ~flip;
         repeat (800) @(posedge aclk);
         rd(CTRL_OFS);
         chk("done held", 32'h1, 32'(rv[CTRL_DONE_POS]));
      end else begin
         n = u_analog_source_model.n_samp;
         repeat (100) @(posedge aclk);
         rd(STATUS_OFS);
         chk("halt", 32'(n), 32'(u_analog_source_model.n_samp) + 32'(rv[3]));
      end
      for (i = 0; i < (c[CTRL_EIGHT_POS] ? 8 : 4); i++) begin
         ch = c[CTRL_GROUP_POS] ? (c[CTRL_EIGHT_POS] ? {c[3], 3'b000} : {c[3:2], 2'b00}) + 4'(i)
                                : c[3:0];
         exp_s[(c[CTRL_EIGHT_POS] ? 0 : 4) + i] = (ch[0] ^ flip) ? 32'h0000_FFC0 : 32'h0000_0000;
         known[(c[CTRL_EIGHT_POS] ? 0 : 4) + i] = 1'b1;
         if (c[CTRL_GROUP_POS] || i == 0) exp_q.push_back(ch);
      end
      for (i = 0; i < 8; i++) begin
         if (known[i]) begin
            rd(RESULT_OFS + 8'(4 * i));
            chk("slot", exp_s[i], rv);
         end
      end
      if (c[CTRL_CONT_POS]) begin
         wr(OPTION_OFS, 32'h0000_0000);
         rd(STATUS_OFS);
         chk("abort", 32'h0, {31'h0, rv[3] | converter_power});
         wr(OPTION_OFS, 32'h0000_0001);
      end else begin
         chk("chans", 32'(exp_q.size()), 32'(u_analog_source_model.chan_q.size()));
         foreach (exp_q[k]) chk("chan", 32'(exp_q[k]), 32'(u_analog_source_model.chan_q[k]));
      end
      $display("test ctrl %h done", c);
   endtask : run
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 80000) begin
         err_total++;
         test_done();
      end
   end
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
      {stop_mode, wait_mode, flip, s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
      s_axi_wstrb <= 4'hF;
      void'($urandom(2));
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(CTRL_OFS);
      chk("ctrl rst", {24'h0, CTRL_RST}, rv);
      rd(OPTION_OFS);
      chk("opt rst", {29'h0, OPT_RST}, rv);
      rd(8'h00);
      chk("unmapped", 32'h2, 32'(rr));
      wr(OPTION_OFS, 32'h0000_0001);
      repeat (10000) @(posedge aclk);
      chk("power", 32'h1, 32'(converter_power));
      for (int i = 0; i < 8; i++) run({1'b0, 3'(i), 4'($urandom())}, 2'(i));
      wr(OPTION_OFS, 32'h0000_0003);
      repeat (1000) @(posedge aclk);
      run({4'h1, 4'($urandom())}, 2'b10);
      chk("rc", 32'h1, 32'(rc_osc_enable));
      test_done();
   end
endmodule : adc_sequence_control_tb_top
